// ==== logic/dsam_monitor.v ====
// Diagnostic flag register, flash checksum test and two-channel alarm logic
`include "dsam_map.vh"

module dsam_monitor (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Register command port
  input wire cmd_valid,
  input wire [15:0] cmd_word,
  output reg rd_valid,
  output reg [15:0] rd_data,
  // Sample timing
  input wire sample_tick,
  // Alarm sources, 14 bits each, source code n at slice n-1
  input wire [153:0] src_unf,
  input wire [153:0] src_flt,
  // Error conditions
  input wire [5:0] st_fail,
  input wire st_diag_err,
  input wire overrange_evt,
  input wire link_fail_evt,
  input wire flash_upd_fail,
  input wire supply_high,
  input wire supply_low,
  // Flash read port
  output reg [5:0] flash_addr,
  input wire [15:0] flash_data,
  input wire [15:0] flash_sum_ref,
  // Digital lines
  output reg dio_one_o,
  output reg dio_one_oe,
  output reg dio_two_o,
  output reg dio_two_oe
);

  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_CMP = 2'd3;

  reg [15:0] diag_q;
  reg [15:0] thr_q [0:1];
  reg [15:0] win_q [0:1];
  reg [15:0] ctrl_q;
  reg [15:0] misc_q;
  reg [15:0] sample_period_setting_q;
  reg [1:0] state_q;
  reg [15:0] acc_q;
  reg dv_q;
  reg chk_fail_set_q;
  wire [1:0] alarm_q;

  wire [6:0] cmd_addr;
  wire [7:0] cmd_data;
  wire wr_en;
  wire rd_en;
  wire [6:0] word_addr;
  wire hi_byte;
  wire rd_diag;
  reg [15:0] rd_mux;
  reg [15:0] set_vec;
  reg [15:0] diag_d;
  wire [1:0] alarm_now;

  assign cmd_addr = cmd_word[`DSAM_CMD_ADDR_HI:`DSAM_CMD_ADDR_LO];
  assign cmd_data = cmd_word[7:0];
  assign wr_en = cmd_valid & cmd_word[`DSAM_CMD_WR];
  assign rd_en = cmd_valid & ~cmd_word[`DSAM_CMD_WR];
  assign word_addr = {cmd_addr[6:1], 1'b0};
  assign hi_byte = cmd_addr[0];
  assign rd_diag = rd_en && (word_addr == `DSAM_ADDR_DIAG);

  // ****************************************************************
  // Register writes (byte wide, as the command carries one byte)
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      thr_q[0] <= `DSAM_RST_THR;
      thr_q[1] <= `DSAM_RST_THR;
      win_q[0] <= `DSAM_RST_WIN;
      win_q[1] <= `DSAM_RST_WIN;
      ctrl_q <= `DSAM_RST_ALARM_CONTROL;
      misc_q <= `DSAM_RST_MISC;
      sample_period_setting_q <= `DSAM_RST_SAMPLE_PERIOD_SETTING;
    end else begin
      // Clear first, so that a new test request in the same cycle wins
      if (state_q == ST_CMP)
        misc_q[`DSAM_MISC_MEMTEST] <= 1'b0;
      if (wr_en) begin
        case (word_addr)
          `DSAM_ADDR_THR_ONE: begin
            if (hi_byte) thr_q[0][15:8] <= cmd_data;
            else thr_q[0][7:0] <= cmd_data;
          end
          `DSAM_ADDR_THR_TWO: begin
            if (hi_byte) thr_q[1][15:8] <= cmd_data;
            else thr_q[1][7:0] <= cmd_data;
          end
          `DSAM_ADDR_WIN_ONE: begin
            if (hi_byte) win_q[0][15:8] <= cmd_data;
            else win_q[0][7:0] <= cmd_data;
          end
          `DSAM_ADDR_WIN_TWO: begin
            if (hi_byte) win_q[1][15:8] <= cmd_data;
            else win_q[1][7:0] <= cmd_data;
          end
          `DSAM_ADDR_ALARM_CONTROL: begin
            if (hi_byte) ctrl_q[15:8] <= cmd_data;
            else ctrl_q[7:0] <= cmd_data;
          end
          `DSAM_ADDR_SAMPLE_PERIOD_SETTING: begin
            if (hi_byte) sample_period_setting_q[15:8] <= cmd_data;
            else sample_period_setting_q[7:0] <= cmd_data;
          end
          `DSAM_ADDR_MISC: begin
            if (hi_byte) begin
              // Test bit only ever set here; finishing the test clears it
              misc_q[15:12] <= cmd_data[7:4];
              misc_q[10:8] <= cmd_data[2:0];
              if (cmd_data[3])
                misc_q[`DSAM_MISC_MEMTEST] <= 1'b1;
            end else begin
              misc_q[7:0] <= cmd_data;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Register reads: answer one cycle after the command
  // ****************************************************************
  always @* begin
    case (word_addr)
      `DSAM_ADDR_DIAG: rd_mux = diag_q;
      `DSAM_ADDR_THR_ONE: rd_mux = thr_q[0];
      `DSAM_ADDR_THR_TWO: rd_mux = thr_q[1];
      `DSAM_ADDR_WIN_ONE: rd_mux = win_q[0];
      `DSAM_ADDR_WIN_TWO: rd_mux = win_q[1];
      `DSAM_ADDR_ALARM_CONTROL: rd_mux = ctrl_q;
      `DSAM_ADDR_MISC: rd_mux = misc_q;
      `DSAM_ADDR_SAMPLE_PERIOD_SETTING: rd_mux = sample_period_setting_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_mux;
    end
  end

  // ****************************************************************
  // Flash checksum test
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      flash_addr <= 6'h00;
      acc_q <= 16'h0000;
      dv_q <= 1'b0;
      chk_fail_set_q <= 1'b0;
    end else begin
      chk_fail_set_q <= 1'b0;
      dv_q <= 1'b0;
      if (dv_q)
        acc_q <= acc_q + flash_data;
      case (state_q)
        ST_IDLE: begin
          if (misc_q[`DSAM_MISC_MEMTEST]) begin
            acc_q <= 16'h0000;
            flash_addr <= 6'h00;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          // Data returns one cycle after its address
          dv_q <= 1'b1;
          if (flash_addr == `DSAM_FLASH_LAST)
            state_q <= ST_WAIT;
          else
            flash_addr <= flash_addr + 6'h01;
        end
        ST_WAIT: begin
          state_q <= ST_CMP;
        end
        ST_CMP: begin
          chk_fail_set_q <= (acc_q != flash_sum_ref);
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Diagnostic flags
  // ****************************************************************
  always @* begin
    set_vec = 16'h0000;
    if (sample_tick) begin
      set_vec[15:10] = st_fail;
      set_vec[9:8] = alarm_now;
      set_vec[`DSAM_DIAG_ST_ERR] = st_diag_err;
      set_vec[`DSAM_DIAG_FLASH_UPD] = flash_upd_fail;
      set_vec[`DSAM_DIAG_SUP_HI] = supply_high;
      set_vec[`DSAM_DIAG_SUP_LO] = supply_low;
    end
    // Short events are caught whenever they occur
    set_vec[`DSAM_DIAG_OVR] = overrange_evt;
    set_vec[`DSAM_DIAG_LINK] = link_fail_evt;
    set_vec[`DSAM_DIAG_CHKSUM] = chk_fail_set_q;
    // Read clears, but a set in the same cycle wins
    diag_d = (rd_diag ? 16'h0000 : diag_q) | set_vec;
    diag_d[`DSAM_DIAG_SUP_HI] = diag_d[`DSAM_DIAG_SUP_HI] & supply_high;
    diag_d[`DSAM_DIAG_SUP_LO] = diag_d[`DSAM_DIAG_SUP_LO] & supply_low;
    diag_d[7] = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (!rst_b)
      diag_q <= `DSAM_RST_DIAG;
    else
      diag_q <= diag_d;
  end

  // ****************************************************************
  // Alarm channels
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : alm
      reg [13:0] hist [0:255];
      reg [7:0] wp_q;
      reg [3:0] src;
      reg [13:0] cur;
      reg [13:0] old;
      reg [7:0] span;
      reg signed [14:0] diff;
      reg signed [14:0] lhs;
      reg signed [14:0] thr;
      reg hit;
      reg alm_q;
      integer i;

      always @* begin
        src = (g == 0) ? ctrl_q[`DSAM_CTRL_SRC1_LO+3:`DSAM_CTRL_SRC1_LO]
                       : ctrl_q[`DSAM_CTRL_SRC2_LO+3:`DSAM_CTRL_SRC2_LO];
        cur = 14'h0000;
        for (i = 0; i < `DSAM_SRC_COUNT; i = i + 1) begin
          if (src == i + 1) begin
            if (ctrl_q[`DSAM_CTRL_FILT])
              cur = src_flt[i*14 +: 14];
            else
              cur = src_unf[i*14 +: 14];
          end
        end
        span = (win_q[g][7:0] == 8'h00) ? 8'h01 : win_q[g][7:0];
        old = hist[wp_q - span];
        diff = {cur[13], cur} - {old[13], old};
        lhs = ctrl_q[`DSAM_CTRL_ROC1 + g] ? diff : {cur[13], cur};
        thr = {thr_q[g][13], thr_q[g][13:0]};
        if (thr_q[g][`DSAM_THR_POL])
          hit = lhs > thr;
        else
          hit = lhs < thr;
        if (src == 4'h0 || src > `DSAM_SRC_COUNT)
          hit = 1'b0;
      end

      // History only advances on samples, so the span is N sample periods
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          wp_q <= 8'h00;
        end else if (sample_tick) begin
          hist[wp_q] <= cur;
          wp_q <= wp_q + 8'h01;
        end
      end

      // Alarm state held between samples; drives the output line
      always @(posedge clk_sys) begin
        if (!rst_b)
          alm_q <= 1'b0;
        else if (sample_tick)
          alm_q <= hit;
      end

      assign alarm_q[g] = alm_q;
      // Flags take the live result, so they agree with the alarm state
      assign alarm_now[g] = hit;
    end
  endgenerate

  // ****************************************************************
  // Alarm output line
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      dio_one_o <= 1'b0;
      dio_one_oe <= 1'b0;
      dio_two_o <= 1'b0;
      dio_two_oe <= 1'b0;
    end else begin
      dio_one_oe <= ctrl_q[`DSAM_CTRL_OUT_EN] & ~ctrl_q[`DSAM_CTRL_OUT_SEL];
      dio_two_oe <= ctrl_q[`DSAM_CTRL_OUT_EN] & ctrl_q[`DSAM_CTRL_OUT_SEL];
      dio_one_o <= (|alarm_q) ~^ ctrl_q[`DSAM_CTRL_OUT_POL];
      dio_two_o <= (|alarm_q) ~^ ctrl_q[`DSAM_CTRL_OUT_POL];
    end
  end

endmodule // dsam_monitor

// ==== include/dsam_map.vh ====
// Register map, field positions, reset values and counts of the alarm monitor
`ifndef DSAM_MAP_VH
`define DSAM_MAP_VH

// ****************************************************************
// Register word addresses (low byte; high byte is address + 1)
// ****************************************************************
`define DSAM_ADDR_THR_ONE 7'h26
`define DSAM_ADDR_THR_TWO 7'h28
`define DSAM_ADDR_WIN_ONE 7'h2a
`define DSAM_ADDR_WIN_TWO 7'h2c
`define DSAM_ADDR_ALARM_CONTROL 7'h2e
`define DSAM_ADDR_MISC 7'h34
`define DSAM_ADDR_SAMPLE_PERIOD_SETTING 7'h36
`define DSAM_ADDR_DIAG 7'h3c

// ****************************************************************
// Reset values
// ****************************************************************
`define DSAM_RST_DIAG 16'h0000
`define DSAM_RST_THR 16'h0000
`define DSAM_RST_WIN 16'h0000
`define DSAM_RST_ALARM_CONTROL 16'h0000
`define DSAM_RST_MISC 16'h0006
`define DSAM_RST_SAMPLE_PERIOD_SETTING 16'h0001

// ****************************************************************
// Command word fields
// ****************************************************************
`define DSAM_CMD_WR 15
`define DSAM_CMD_ADDR_HI 14
`define DSAM_CMD_ADDR_LO 8

// ****************************************************************
// Field positions
// ****************************************************************
`define DSAM_MISC_MEMTEST 11
`define DSAM_DIAG_SUP_HI 1
`define DSAM_DIAG_SUP_LO 0
`define DSAM_DIAG_FLASH_UPD 2
`define DSAM_DIAG_LINK 3
`define DSAM_DIAG_OVR 4
`define DSAM_DIAG_ST_ERR 5
`define DSAM_DIAG_CHKSUM 6
`define DSAM_DIAG_ALM_LO 8
`define DSAM_DIAG_ST_LO 10
`define DSAM_THR_POL 15
`define DSAM_THR_DATA_HI 13
`define DSAM_CTRL_SRC2_LO 12
`define DSAM_CTRL_SRC1_LO 8
`define DSAM_CTRL_ROC1 6
`define DSAM_CTRL_FILT 4
`define DSAM_CTRL_OUT_EN 2
`define DSAM_CTRL_OUT_POL 1
`define DSAM_CTRL_OUT_SEL 0

// ****************************************************************
// Sizes and counts
// ****************************************************************
`define DSAM_SRC_COUNT 11
`define DSAM_DATA_W 14
`define DSAM_HIST_DEPTH 256
`define DSAM_FLASH_WORDS 64
`define DSAM_FLASH_LAST 6'h3f

`endif

// ==== tb/dsam_chk_sva.sv ====
// Port checks for the alarm monitor
module dsam_chk (
  // Clock and reset
  input logic clk_sys,
  input logic rst_b,
  // Register port
  input logic cmd_valid,
  input logic [15:0] cmd_word,
  input logic rd_valid,
  input logic [15:0] rd_data,
  // Status inputs and outputs
  input logic sample_tick,
  input logic supply_high,
  input logic [5:0] flash_addr,
  input logic dio_one_o,
  input logic dio_one_oe,
  input logic dio_two_o,
  input logic dio_two_oe
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] ctl_q;
  logic armed_q;
  wire rd_cmd = cmd_valid && !cmd_word[15];
  wire dread = cmd_valid && cmd_word[15:9] == 7'h1e;
  wire mt_go = cmd_valid && cmd_word[15:8] == 8'hb5 && cmd_word[3];
  always @(posedge clk_sys) begin
    if (!rst_b)
      ctl_q <= 8'h00;
    else if (cmd_valid && cmd_word[15:8] == 8'hae)
      ctl_q <= cmd_word[7:0];
  end
  // Armed: a flag read happened with no sample since
  always @(posedge clk_sys) begin
    if (!rst_b || sample_tick)
      armed_q <= 1'b0;
    else if (dread)
      armed_q <= 1'b1;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  rd_pulse_a: assert property (rd_valid == $past(rd_cmd))
    else $error("read answer pulse mismatch");
  read_clear_a: assert property (dread && armed_q |=>
    rd_data[15:7] == 9'h000 && !rd_data[5] && !rd_data[2])
    else $error("flags not cleared by read");
  sup_clear_a: assert property (rd_valid && $past(dread) &&
    !$past(supply_high, 2) && !$past(supply_high, 3) |-> !rd_data[1])
    else $error("supply flag stuck");
  oe_excl_a: assert property (!(dio_one_oe && dio_two_oe))
    else $error("both lines driven");
  oe_sel_a: assert property ($past(sample_tick, 2) &&
    ctl_q == $past(ctl_q) && ctl_q == $past(ctl_q, 2) |->
    dio_one_oe == (ctl_q[2] && !ctl_q[0]) &&
    dio_two_oe == (ctl_q[2] && ctl_q[0]))
    else $error("line enable mismatch");
  line_same_a: assert property (dio_one_o == dio_two_o)
    else $error("line levels differ");
  addr_step_a: assert property (flash_addr != $past(flash_addr) |->
    flash_addr == $past(flash_addr) + 6'h01)
    else $error("flash address skipped");
  scan_end_a: assert property (mt_go |-> ##[60:70] flash_addr == 6'h3f)
    else $error("checksum scan late");
  mt_c: cover property (mt_go);
  clr_c: cover property (dread && armed_q);
  pin_c: cover property (dio_one_oe && dio_one_o);
endmodule // dsam_chk

bind dsam_monitor dsam_chk dsam_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_valid(rd_valid),
  .rd_data(rd_data), .sample_tick(sample_tick), .supply_high(supply_high),
  .flash_addr(flash_addr), .dio_one_o(dio_one_o), .dio_one_oe(dio_one_oe),
  .dio_two_o(dio_two_o), .dio_two_oe(dio_two_oe));

// ==== tb/dsam_host.sv ====
// Host model issuing register commands
module dsam_host (
  // Clock
  input logic clk_sys,
  // Command port
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  input logic rd_valid,
  input logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end
  // Idle word inverted so a stale command is never reused
  task automatic put(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    cmd_valid = 1'b1;
    cmd_word = {w, a, d};
    @(posedge clk_sys);
    #2;
    cmd_valid = 1'b0;
    cmd_word = ~cmd_word;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    int k;
    put(1'b0, a, 8'h00);
    k = 0;
    // Answer stands one cycle from the edge that took the command
    while (rd_valid !== 1'b1 && k < 4) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (rd_valid !== 1'b1)
      diag_status_alarm_monitor_tb_top.timed_out();
    d = rd_data;
  endtask
endmodule // dsam_host

// ==== tb/diag_status_alarm_monitor_tb_top.sv ====
// Testbench for the diagnostic flag and alarm monitor
module diag_status_alarm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_b = 1'b0, sample_tick = 1'b0;
  logic st_diag_err = 1'b0, overrange_evt = 1'b0, link_fail_evt = 1'b0;
  logic flash_upd_fail = 1'b0, supply_high = 1'b0, supply_low = 1'b0;
  logic [153:0] src_unf = 154'h0, src_flt = 154'h0;
  logic [5:0] st_fail = 6'h00;
  logic [15:0] fl_ref = 16'h0000, rdv;
  logic [15:0] pat [5] = '{16'h9abc, 16'h3fff, 16'h00ff, 16'h0081, 16'h76c7};
  logic [6:0] ra;
  wire cmd_valid, rd_valid, dio_one_o, dio_one_oe, dio_two_o, dio_two_oe;
  wire [15:0] cmd_word, rd_data;
  logic [15:0] flash_data = 16'h0000;
  wire [5:0] flash_addr;
  int n_errors = 0, n_tests = 0;
  always #10 clk_sys = ~clk_sys;
  // Flash word comes one cycle after its address
  always @(posedge clk_sys)
    flash_data <= {2'h0, flash_addr, 2'h0, flash_addr};
  dsam_monitor dsam_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_valid(rd_valid),
    .rd_data(rd_data), .sample_tick(sample_tick), .src_unf(src_unf),
    .src_flt(src_flt), .st_fail(st_fail), .st_diag_err(st_diag_err),
    .overrange_evt(overrange_evt), .link_fail_evt(link_fail_evt),
    .flash_upd_fail(flash_upd_fail), .supply_high(supply_high),
    .supply_low(supply_low), .flash_addr(flash_addr),
    .flash_data(flash_data), .flash_sum_ref(fl_ref), .dio_one_o(dio_one_o),
    .dio_one_oe(dio_one_oe), .dio_two_o(dio_two_o), .dio_two_oe(dio_two_oe));
  dsam_host dsam_host_i (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .rd_valid(rd_valid), .rd_data(rd_data));
  // ****************************************
  // Tasks
  // ****************************************
  task conclude;
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task timed_out;
    n_errors++;
    $display("wrong value at %0t ns: no read answer", $time);
    conclude;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h, want %h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge clk_sys);
    #2;
  endtask
  task rdc(input logic [6:0] a, input logic [15:0] e);
    dsam_host_i.rd(a, rdv);
    chk(rdv, e);
  endtask
  task wr16(input logic [6:0] a, input logic [15:0] d);
    dsam_host_i.wr(a + 7'h01, d[15:8]);
    dsam_host_i.wr(a, d[7:0]);
  endtask
  // One sample with given source values, then the line state is checked
  task tk(input int s, input logic [13:0] vf, vu, input logic [2:0] e);
    step;
    src_flt = 154'h0;
    src_unf = 154'h0;
    src_flt[s*14 +: 14] = vf;
    src_unf[s*14 +: 14] = vu;
    sample_tick = 1'b1;
    step;
    sample_tick = 1'b0;
    repeat (2) step;
    chk({13'h0, dio_one_o, dio_one_oe, dio_two_oe}, {13'h0, e});
  endtask
  task mt(input logic bad);
    fl_ref = {15'h0, bad};
    for (int i = 0; i < 64; i++)
      fl_ref = fl_ref + {2'h0, i[5:0], 2'h0, i[5:0]};
    dsam_host_i.wr(7'h35, 8'h08);
    rdc(7'h34, 16'h0806);
    repeat (80) step;
    rdc(7'h34, 16'h0006);
    rdc(7'h3c, {9'h000, bad, 6'h00});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) step;
    rst_b = 1'b1;
    mt(1'b0);
    mt(1'b1);
    rdc(7'h3c, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      ra = 7'h26 + {i[5:0], 1'b0};
      rdc(ra, 16'h0000);
      wr16(ra, pat[i]);
      rdc(ra, pat[i]);
    end
    rdc(7'h40, 16'h0000);
    wr16(7'h2e, 16'h5517);
    wr16(7'h26, 16'h8096);
    wr16(7'h28, 16'h376a);
    for (int c = 1; c < 12; c++) begin
      dsam_host_i.wr(7'h2f, {c[3:0], c[3:0]});
      tk(c - 1, 14'h0100, 14'h0000, 3'b101);
      rdc(7'h3c, 16'h0100);
    end
    tk(10, 14'h3000, 14'h0000, 3'b101);
    rdc(7'h3c, 16'h0200);
    tk(10, 14'h0000, 14'h0100, 3'b001);
    dsam_host_i.wr(7'h2e, 8'h14);
    tk(10, 14'h0000, 14'h0000, 3'b110);
    tk(10, 14'h0100, 14'h0000, 3'b010);
    dsam_host_i.wr(7'h2f, 8'h00);
    tk(10, 14'h0100, 14'h0000, 3'b110);
    dsam_host_i.wr(7'h2f, 8'h01);
    dsam_host_i.wr(7'h2e, 8'h46);
    dsam_host_i.wr(7'h2a, 8'h03);
    wr16(7'h26, 16'h8010);
    for (int i = 0; i < 8; i++)
      tk(0, 14'h0, i > 3 ? 14'h20 : 14'h0, {i > 3 && i < 7, 2'b10});
    dsam_host_i.wr(7'h2a, 8'h00);
    tk(0, 14'h0000, 14'h0040, 3'b110);
    tk(0, 14'h0000, 14'h0040, 3'b010);
    dsam_host_i.rd(7'h3c, rdv);
    step;
    st_fail = 6'h21;
    {st_diag_err, flash_upd_fail, supply_high, supply_low} = 4'hf;
    {overrange_evt, link_fail_evt} = 2'h3;
    step;
    {overrange_evt, link_fail_evt} = 2'h0;
    tk(0, 14'h0000, 14'h0000, 3'b010);
    rdc(7'h3c, 16'h843f);
    rdc(7'h3c, 16'h0000);
    tk(0, 14'h0000, 14'h0000, 3'b010);
    {supply_high, supply_low} = 2'h0;
    repeat (3) step;
    rdc(7'h3c, 16'h8424);
    // Alarm 2 in rate mode, one-sample window, falling by more than limit
    dsam_host_i.wr(7'h2c, 8'h01);
    dsam_host_i.wr(7'h2f, 8'h10);
    dsam_host_i.wr(7'h2e, 8'h86);
    tk(0, 14'h0000, 14'h3000, 3'b110);
    tk(0, 14'h0000, 14'h3000, 3'b010);
    rdc(7'h3c, 16'h8624);
    conclude;
  end
endmodule // diag_status_alarm_monitor_tb_top
